// ---- inc/piosd_pkg.sv ----
// Constants and address map of the peripheral I/O space decoder
package piosd_pkg;

  // ***************************************************************
  // Bus widths
  // ***************************************************************
  localparam int IO_AW = 16;
  localparam int IO_DW = 16;
  localparam int IO_BEW = 2;
  localparam int LEG_AW = 10;
  localparam int N_CH = 16;

  // ***************************************************************
  // Address map control register
  // ***************************************************************
  localparam logic [IO_AW-1:0] CFG_WORD_ADDR = 16'h0022;
  localparam logic [IO_AW-1:0] CFG_HI_ADDR = 16'h0023;
  localparam logic [IO_DW-1:0] CFG_RESET = 16'h0000;
  localparam logic [IO_DW-1:0] CFG_REMAP_MASK = 16'h007D;
  localparam int EXP_EN_POS = 15;
  localparam int TIMER_REMAP_POS = 0;
  localparam int DMA_REMAP_POS = 2;
  localparam int MASTER_PIC_REMAP_POS = 3;
  localparam int SLAVE_PIC_REMAP_POS = 4;
  localparam int SERIAL0_REMAP_POS = 5;
  localparam int SERIAL1_REMAP_POS = 6;
  localparam logic [IO_BEW-1:0] BE_LO = 2'h1;
  localparam logic [IO_BEW-1:0] BE_HI = 2'h2;
  localparam logic [IO_BEW-1:0] BE_WORD = 2'h3;
  localparam logic [7:0] EXP_EN_CLEAR_VALUE = 8'h00;

  // ***************************************************************
  // Peripheral windows, one entry per select line
  // ***************************************************************
  // 0 DMA, 1 master PIC, 2 timer, 3 DMA page, 4 slave PIC, 5 math
  // coprocessor, 6 chip select, 7 sync serial, 8 refresh, 9 watchdog,
  // 10 serial_port_zero, 11 clock/power, 12 bus interface,
  // 13 chip configuration, 14 parallel I/O, 15 serial_port_one
  localparam logic [IO_AW-1:0] CH_BASE [N_CH] = '{
    16'hF000, 16'hF020, 16'hF040, 16'hF080, 16'hF0A0, 16'hF0F0,
    16'hF400, 16'hF480, 16'hF4A0, 16'hF4C0, 16'hF4F8, 16'hF800,
    16'hF810, 16'hF820, 16'hF860, 16'hF8F8};
  localparam logic [IO_AW-1:0] CH_SPAN [N_CH] = '{
    16'h001F, 16'h001F, 16'h001F, 16'h001F, 16'h001F, 16'h000F,
    16'h007F, 16'h001F, 16'h001F, 16'h000F, 16'h0007, 16'h000F,
    16'h000F, 16'h001F, 16'h001F, 16'h0007};
  localparam logic [LEG_AW-1:0] CH_LEG_BASE [N_CH] = '{
    10'h000, 10'h020, 10'h040, 10'h080, 10'h0A0, 10'h0F0,
    10'h000, 10'h000, 10'h000, 10'h000, 10'h3F8, 10'h000,
    10'h000, 10'h000, 10'h000, 10'h2F8};
  localparam logic [N_CH-1:0] CH_HAS_LEG = 16'h843F;
  localparam logic [IO_DW-1:0] CH_REMAP_SEL [N_CH] = '{
    16'h0004, 16'h0008, 16'h0001, 16'h0004, 16'h0010, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0020, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0040};

endpackage : piosd_pkg

// ---- src/piosd_unlock.sv ----
// Write sequence detector that unlocks the expanded I/O space
`timescale 1ns/100ps
`default_nettype none

module piosd_unlock (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_stb,
  input wire logic hit_hi_byte,
  input wire logic hit_lo_byte,
  input wire logic hit_word,
  output logic unlock
);
  import piosd_pkg::*;

  typedef enum logic [1:0] {
    PIOSD_IDLE,
    PIOSD_GOT_HI,
    PIOSD_GOT_LO
  } piosd_unlock_state_t;

  piosd_unlock_state_t state_q;
  piosd_unlock_state_t state_d;

  // ***************************************************************
  // Sequence: high byte, low byte, then word, back to back
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    unlock = 1'b0;
    if (wr_stb) begin
      case (state_q)
        PIOSD_IDLE: begin
          state_d = hit_hi_byte ? PIOSD_GOT_HI : PIOSD_IDLE;
        end
        PIOSD_GOT_HI: begin
          state_d = hit_lo_byte ? PIOSD_GOT_LO : PIOSD_IDLE;
        end
        PIOSD_GOT_LO: begin
          unlock = hit_word;
          state_d = PIOSD_IDLE;
        end
        default: begin
          state_d = PIOSD_IDLE;
        end
      endcase
      // A stray high byte write restarts the sequence
      if (state_q != PIOSD_IDLE && hit_hi_byte && !unlock) begin
        state_d = PIOSD_GOT_HI;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= PIOSD_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

endmodule : piosd_unlock

`default_nettype wire

// ---- src/piosd_decoder.sv ----
// Peripheral I/O space decoder with address map control register
`timescale 1ns/100ps
`default_nettype none

module piosd_decoder (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [piosd_pkg::IO_AW-1:0] io_addr,
  input wire logic [piosd_pkg::IO_DW-1:0] io_wdata,
  input wire logic [piosd_pkg::IO_BEW-1:0] io_be,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [piosd_pkg::N_CH-1:0] periph_sel,
  output logic periph_wr,
  output logic periph_rd,
  output logic ext_cycle,
  output logic cfg_rd_hit,
  output logic [piosd_pkg::IO_DW-1:0] io_rdata,
  output logic expanded_space_enable,
  output logic [piosd_pkg::IO_DW-1:0] address_remap_config
);
  import piosd_pkg::*;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic exp_en_q;
  logic exp_en_d;
  logic [IO_DW-1:0] remap_q;
  logic [IO_DW-1:0] remap_d;
  logic [N_CH-1:0] sel_q;
  logic [N_CH-1:0] sel_d;
  logic wr_q;
  logic wr_d;
  logic rd_q;
  logic rd_d;
  logic ext_q;
  logic ext_d;
  logic cfg_rd_q;
  logic cfg_rd_d;
  logic [IO_DW-1:0] rdata_q;
  logic [IO_DW-1:0] rdata_d;
  logic stb;
  logic upper_zero;
  logic cfg_word;
  logic hit_hi_byte;
  logic hit_lo_byte;
  logic hit_word;
  logic cfg_hit;
  logic unlock;
  logic [N_CH-1:0] exp_hit;
  logic [N_CH-1:0] leg_hit;
  logic [N_CH-1:0] ch_hit;
  logic [IO_DW-1:0] cfg_view;

  assign stb = io_wr | io_rd;

  // ***************************************************************
  // Map control register address decode
  // ***************************************************************
  // Upper lines only count once the expanded region is on
  assign upper_zero = (io_addr[IO_AW-1:LEG_AW] == '0);
  assign cfg_word = (io_addr[LEG_AW-1:1] == CFG_WORD_ADDR[LEG_AW-1:1]) &&
                    (!exp_en_q || upper_zero);
  assign hit_hi_byte = cfg_word && (io_be == BE_HI) &&
                       io_addr[0];
  assign hit_lo_byte = cfg_word && (io_be == BE_LO) &&
                       !io_addr[0];
  assign hit_word = cfg_word && (io_be == BE_WORD) &&
                    !io_addr[0];
  assign cfg_hit = hit_hi_byte | hit_lo_byte | hit_word;

  piosd_unlock u_unlock (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .wr_stb(io_wr),
    .hit_hi_byte(hit_hi_byte),
    .hit_lo_byte(hit_lo_byte),
    .hit_word(hit_word),
    .unlock(unlock)
  );

  // ***************************************************************
  // Per peripheral window decode
  // ***************************************************************
  generate
    for (genvar i = 0; i < N_CH; i++) begin : g_ch
      // Expanded window, full sixteen-bit compare in the top slot
      assign exp_hit[i] = exp_en_q &&
        ((io_addr & ~CH_SPAN[i]) == CH_BASE[i]);
      // Legacy window, ten-bit compare, gated by the remap bit
      assign leg_hit[i] = CH_HAS_LEG[i] &&
        ((remap_q & CH_REMAP_SEL[i]) == '0) &&
        (!exp_en_q || upper_zero) &&
        ((io_addr[LEG_AW-1:0] & ~CH_SPAN[i][LEG_AW-1:0]) ==
         CH_LEG_BASE[i]);
      // The map register takes priority over the master PIC alias
      assign ch_hit[i] = (exp_hit[i] | leg_hit[i]) && !cfg_hit;
    end
  endgenerate

  // ***************************************************************
  // Map control register
  // ***************************************************************
  always_comb begin
    exp_en_d = exp_en_q;
    remap_d = remap_q;
    if (io_wr) begin
      // Locked register ignores data writes
      if (exp_en_q && (hit_lo_byte || hit_word)) begin
        remap_d = io_wdata & CFG_REMAP_MASK;
      end
      if (exp_en_q && hit_hi_byte &&
          io_wdata[IO_DW-1:8] == EXP_EN_CLEAR_VALUE) begin
        exp_en_d = 1'b0;
      end
      if (unlock) begin
        exp_en_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      exp_en_q <= CFG_RESET[EXP_EN_POS];
      remap_q <= CFG_RESET;
    end else if (ce) begin
      exp_en_q <= exp_en_d;
      remap_q <= remap_d;
    end
  end

  // ***************************************************************
  // Read view of the map register
  // ***************************************************************
  always_comb begin
    cfg_view = remap_q & CFG_REMAP_MASK;
    cfg_view[EXP_EN_POS] = exp_en_q;
  end

  // ***************************************************************
  // Registered cycle outputs
  // ***************************************************************
  always_comb begin
    sel_d = '0;
    wr_d = 1'b0;
    rd_d = 1'b0;
    ext_d = 1'b0;
    cfg_rd_d = 1'b0;
    rdata_d = rdata_q;
    if (stb) begin
      sel_d = ch_hit;
      wr_d = io_wr && (ch_hit != '0);
      rd_d = io_rd && (ch_hit != '0);
      ext_d = (ch_hit == '0) && !cfg_hit;
      cfg_rd_d = io_rd && cfg_hit;
      if (io_rd && cfg_hit) begin
        rdata_d = cfg_view;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_q <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ext_q <= 1'b0;
      cfg_rd_q <= 1'b0;
      rdata_q <= '0;
    end else if (ce) begin
      sel_q <= sel_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      ext_q <= ext_d;
      cfg_rd_q <= cfg_rd_d;
      rdata_q <= rdata_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign periph_sel = sel_q;
  assign periph_wr = wr_q;
  assign periph_rd = rd_q;
  assign ext_cycle = ext_q;
  assign cfg_rd_hit = cfg_rd_q;
  assign io_rdata = rdata_q;
  assign expanded_space_enable = exp_en_q;
  assign address_remap_config = remap_q;

endmodule : piosd_decoder

`default_nettype wire

// ---- dv/piosd_decoder_monitor.sv ----
// Port timing checker for the peripheral I/O space decoder
`timescale 1ns/100ps
`default_nettype none
module piosd_decoder_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [piosd_pkg::IO_AW-1:0] io_addr,
  input wire logic [piosd_pkg::IO_DW-1:0] io_wdata,
  input wire logic [piosd_pkg::IO_BEW-1:0] io_be,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [piosd_pkg::N_CH-1:0] periph_sel,
  input wire logic periph_wr,
  input wire logic periph_rd,
  input wire logic ext_cycle,
  input wire logic cfg_rd_hit,
  input wire logic [piosd_pkg::IO_DW-1:0] io_rdata,
  input wire logic expanded_space_enable,
  input wire logic [piosd_pkg::IO_DW-1:0] address_remap_config
);
  import piosd_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_sel_onehot: assert property ($onehot0(periph_sel))
    else $error("select not one-hot");
  a_sel_cause: assert property ((periph_sel != '0 && $past(ce)) |->
    $past(io_wr || io_rd)) else $error("select without request");
  a_wr_kind: assert property ((periph_wr && $past(ce)) |->
    $past(io_wr) && periph_sel != '0) else $error("bad write pulse");
  a_ext_alone: assert property (ext_cycle |->
    periph_sel == '0 && !cfg_rd_hit) else $error("external overlaps");
  a_cfg_read: assert property ((cfg_rd_hit && $past(ce)) |->
    $past(io_rd) && ($past(io_addr[LEG_AW-1:0]) | 10'h001) ==
    CFG_HI_ADDR[LEG_AW-1:0]) else $error("cfg read");
  a_rdata_fmt: assert property (cfg_rd_hit |-> io_rdata ==
    ({expanded_space_enable, 15'h0000} | address_remap_config))
    else $error("map read format");
  a_rsvd_zero: assert property (
    (address_remap_config & ~CFG_REMAP_MASK) == '0)
    else $error("reserved bit set");
  a_map_locked: assert property (!$past(expanded_space_enable) |->
    $stable(address_remap_config)) else $error("locked map changed");
  a_enable_rise: assert property ($rose(expanded_space_enable) |->
    $past(io_wr) && $past(io_be) == BE_WORD &&
    $past(io_addr[LEG_AW-1:0]) == CFG_WORD_ADDR[LEG_AW-1:0])
    else $error("enable set wrongly");
  a_enable_fall: assert property ($fell(expanded_space_enable) |->
    $past(io_wr) && $past(io_addr) == CFG_HI_ADDR && $past(io_be) == BE_HI
    && ($past(io_wdata) & 16'hFF00) == '0) else $error("enable cleared");
endmodule : piosd_decoder_monitor
bind piosd_decoder piosd_decoder_monitor u_mon (.clk_sys(clk_sys), .rst(rst),
  .ce(ce), .io_addr(io_addr), .io_wdata(io_wdata), .io_be(io_be),
  .io_wr(io_wr), .io_rd(io_rd), .periph_sel(periph_sel),
  .periph_wr(periph_wr), .periph_rd(periph_rd), .ext_cycle(ext_cycle),
  .cfg_rd_hit(cfg_rd_hit), .io_rdata(io_rdata),
  .expanded_space_enable(expanded_space_enable),
  .address_remap_config(address_remap_config));
`default_nettype wire

// ---- dv/piosd_core_model.sv ----
// Processor core model issuing single-cycle internal I/O requests
`timescale 1ns/100ps
`default_nettype none
module piosd_core_model (
  input wire logic clk_sys,
  output logic [piosd_pkg::IO_AW-1:0] io_addr,
  output logic [piosd_pkg::IO_DW-1:0] io_wdata,
  output logic [piosd_pkg::IO_BEW-1:0] io_be,
  output logic io_wr,
  output logic io_rd
);
  import piosd_pkg::*;
  initial begin
    io_addr = '0;
    io_wdata = '0;
    io_be = BE_WORD;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end
  // Sixteen-bit request for one cycle; address and data lines then show inverted junk
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [15:0] d, input logic [1:0] b);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= d;
    io_be <= b;
    io_wr <= w;
    io_rd <= !w;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    @(negedge clk_sys);
  endtask : access
endmodule : piosd_core_model
`default_nettype wire

// ---- dv/tb_peripheral_io_space_decoder.sv ----
// Self-checking bench of the peripheral I/O space decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_peripheral_io_space_decoder;
  import piosd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [IO_AW-1:0] io_addr;
  logic [IO_DW-1:0] io_wdata, io_rdata, address_remap_config;
  logic [IO_BEW-1:0] io_be;
  logic io_wr, io_rd, periph_wr, periph_rd, ext_cycle, cfg_rd_hit;
  logic expanded_space_enable;
  logic [N_CH-1:0] periph_sel;
  logic [52:0] outs_all;
  assign outs_all = {periph_sel, periph_wr, periph_rd, ext_cycle, cfg_rd_hit,
    io_rdata, expanded_space_enable, address_remap_config};
  int n_fail = 0;
  int tests_run = 0;
  int m_en = 0;
  int m_map = 0;
  int m_stage = 0;
  always #25 clk_sys = ~clk_sys;
  piosd_core_model CORE (.clk_sys(clk_sys), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_be(io_be), .io_wr(io_wr), .io_rd(io_rd));
  piosd_decoder DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_be(io_be), .io_wr(io_wr), .io_rd(io_rd),
    .periph_sel(periph_sel), .periph_wr(periph_wr), .periph_rd(periph_rd),
    .ext_cycle(ext_cycle), .cfg_rd_hit(cfg_rd_hit), .io_rdata(io_rdata),
    .expanded_space_enable(expanded_space_enable),
    .address_remap_config(address_remap_config));
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // One request against the reference decode and map state
  task automatic op(input bit w, input logic [15:0] a, input logic [15:0] d,
                    input logic [1:0] b);
    logic [N_CH-1:0] es;
    logic [9:0] lo;
    bit cfg;
    cfg = (a == CFG_WORD_ADDR && b != BE_HI) ||
          (a == CFG_HI_ADDR && b == BE_HI);
    es = '0;
    for (int i = 0; i < N_CH; i++) begin
      lo = a[9:0] - CH_LEG_BASE[i];
      if (m_en != 0 && a - CH_BASE[i] <= CH_SPAN[i]) es[i] = !cfg;
      if (CH_HAS_LEG[i] && (m_map & CH_REMAP_SEL[i]) == 0 &&
          (m_en == 0 || a[15:10] == 0) && lo <= CH_SPAN[i][9:0]) begin
        es[i] = !cfg;
      end
    end
    CORE.access(w, a, d, b);
    `CHK("sel", es, periph_sel)
    `CHK("wr", w && es != 0, periph_wr)
    `CHK("rd", !w && es != 0, periph_rd)
    `CHK("ext", !cfg && es == 0, ext_cycle)
    `CHK("cfg_rd", cfg && !w, cfg_rd_hit)
    if (cfg && !w) `CHK("rdata", m_map | m_en << 15, io_rdata)
    if (w) begin
      if (m_en != 0 && cfg && b != BE_HI) m_map = d & CFG_REMAP_MASK;
      if (m_en != 0 && cfg && b == BE_HI && d[15:8] == 0) m_en = 0;
      if (m_en == 0) begin
        if (m_stage == 2 && a == CFG_WORD_ADDR && b == BE_WORD) m_en = 1;
        m_stage = (a == CFG_HI_ADDR && b == BE_HI) ? 1 :
          (m_stage == 1 && a == CFG_WORD_ADDR && b == BE_LO) ? 2 : 0;
      end
    end
    `CHK("enable", m_en[0], expanded_space_enable)
    `CHK("map", m_map[15:0], address_remap_config)
  endtask : op
  // Every window: expanded place, legacy place, legacy alias
  task automatic sweep();
    logic [15:0] a;
    for (int i = 0; i < N_CH; i++) begin
      for (int k = 0; k < 3; k++) begin
        a = 16'($urandom) & CH_SPAN[i];
        a = k == 0 ? CH_BASE[i] + a : {k == 1 ? 6'h00 : 6'($urandom),
          CH_LEG_BASE[i] + a[9:0]};
        if (a[9:1] == 9'h011) a = a ^ 16'h0004;
        op(1'($urandom), a, 16'($urandom), a[0] ? BE_HI : BE_LO);
      end
    end
  endtask : sweep
  initial begin
    void'($urandom(32'hab242121));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    `CHK("reset", 53'h0, outs_all)
    op(0, CFG_WORD_ADDR, 16'h0000, BE_WORD);
    sweep();
    op(1, CFG_HI_ADDR, 16'h8000, BE_HI);
    op(1, CFG_WORD_ADDR, 16'h0080, BE_LO);
    op(1, 16'h0100, 16'h0000, BE_LO);
    op(1, CFG_WORD_ADDR, 16'h007D, BE_WORD);
    op(1, CFG_HI_ADDR, 16'h8000, BE_HI);
    op(0, CFG_HI_ADDR, 16'h0000, BE_HI);
    op(1, CFG_WORD_ADDR, 16'h0080, BE_LO);
    op(1, CFG_WORD_ADDR, 16'h8000, BE_WORD);
    // Clock enable low: requests are not taken and no state moves
    @(posedge clk_sys) ce <= 1'b0;
    CORE.access(0, 16'hF810, 16'h0000, BE_LO);
    `CHK("frozen_sel", 16'h0000, periph_sel)
    CORE.access(1, CFG_HI_ADDR, 16'h0000, BE_HI);
    `CHK("frozen_en", 1'b1, expanded_space_enable)
    @(posedge clk_sys) ce <= 1'b1;
    op(1, CFG_HI_ADDR, 16'h5A00, BE_HI);
    for (int r = 0; r < 3; r++) begin
      op(1, CFG_WORD_ADDR, r == 0 ? 16'h0000 : r == 1 ? 16'h00FF :
        16'($urandom), BE_LO);
      sweep();
    end
    op(0, CFG_WORD_ADDR, 16'h0000, BE_WORD);
    op(1, CFG_HI_ADDR, 16'h0000, BE_HI);
    sweep();
    op(1, CFG_WORD_ADDR, 16'h0000, BE_LO);
    op(0, CFG_WORD_ADDR, 16'h0000, BE_WORD);
    // Unlock again, remap everything, then reset in mid-run
    op(1, CFG_HI_ADDR, 16'h8000, BE_HI);
    op(1, CFG_WORD_ADDR, 16'h0080, BE_LO);
    op(1, CFG_WORD_ADDR, 16'h8000, BE_WORD);
    op(1, CFG_WORD_ADDR, 16'h007D, BE_LO);
    @(posedge clk_sys) rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    m_en = 0;
    m_map = 0;
    m_stage = 0;
    `CHK("reset_mid", 53'h0, outs_all)
    op(0, CFG_WORD_ADDR, 16'h0000, BE_WORD);
    op(0, 16'h0004, 16'h0000, BE_LO);
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    test_done();
  end
endmodule : tb_peripheral_io_space_decoder
`default_nettype wire
